/* include/swcfg_pkg.sv */
// constants and types for the switch configuration control block
// assumes a single 25 MHz clock domain and a synchronous active-high reset
//
// Function
// - any serial access latches serial control until the next reset
// - routing supports quad 4:1, dual 8:1 and single 16:1 arrangements
// - serial control selects any arrangement; fast and aux modes independent
// - parallel control forces quad; pin channel select drives fast and aux together
// - serial slave answers at one of eight addresses set by address pins
// - reset returns every control register to its default value
// - inputs with pulse bit set lose termination for about 100 ms after a switch
// - global termination-off bit disconnects all inputs; connected by default
// - under parallel control inputs stay terminated; pulse and off ignored
// - each input equalizer takes low or high boost from its serial bit
// - under parallel control one pin sets every equalizer level
// - output termination follows serial bit or parallel pin
// - outputs tristate by serial enable bit or parallel enable pin
// - on reset output termination setting takes the pin value
// - one bit or pin selects high or low output current level
// - on reset output current setting takes the pin value
// - pre-emphasis picks one of four levels from field or pin bus
// - after reset the pins govern until the first serial event
// - under serial control fast switching arrangement comes from the serial mode bits
package swcfg_pkg;

   // ==========================================================
   // switching arrangements
   localparam logic [1:0] SWCFG_MODE_QUAD   = 2'h0;
   localparam logic [1:0] SWCFG_MODE_DUAL   = 2'h1;
   localparam logic [1:0] SWCFG_MODE_SINGLE = 2'h2;

   // ==========================================================
   // serial slave address: fixed upper bits, low three from pins
   localparam logic [3:0] SWCFG_ADDR_HIGH = 4'h9;

   // ==========================================================
   // reset values of serial-side settings
   localparam logic [1:0]  SWCFG_RST_MODE    = 2'h0;
   localparam logic [3:0]  SWCFG_RST_CHAN    = 4'h0;
   localparam logic [15:0] SWCFG_RST_PULSE   = 16'h0000;
   localparam logic        SWCFG_RST_TERMOFF = 1'b0;
   localparam logic [15:0] SWCFG_RST_EQ      = 16'h0000;
   localparam logic        SWCFG_RST_OE      = 1'b0;
   localparam logic [1:0]  SWCFG_RST_BOOST   = 2'h0;

   // ==========================================================
   // termination pulse timing
   localparam int          SWCFG_CLK_HZ      = 25_000_000;
   localparam int          SWCFG_PULSE_MS    = 100;
   localparam int          SWCFG_PULSE_CYC   = SWCFG_CLK_HZ / 1000 * SWCFG_PULSE_MS;
   localparam int          SWCFG_CNT_W       = 22;

   typedef enum logic [1:0] {
      SWCFG_SRC_PIN    = 2'b01,
      SWCFG_SRC_SERIAL = 2'b10
   } swcfg_src_t;

endpackage

/* logic/swcfg_ctrl.sv */
// switch configuration control: picks serial or pin source, drives settings
// assumes serial register writes arrive already decoded, in mclk domain;
// pin inputs are asynchronous straps and are synchronised here
module swcfg_ctrl #(
   parameter int PULSE_CYC = swcfg_pkg::SWCFG_PULSE_CYC
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   // serial slave side, already decoded
   input  wire logic [6:0]  ser_dev_addr,
   input  wire logic        ser_access,
   input  wire logic        ser_wr_mode,
   input  wire logic [1:0]  fast_switch_mode_bits,
   input  wire logic [3:0]  ser_fast_chan,
   input  wire logic [1:0]  ser_aux_mode,
   input  wire logic [3:0]  ser_aux_chan,
   input  wire logic        ser_wr_term,
   input  wire logic [15:0] input_term_pulse_bits,
   input  wire logic        input_term_off,
   input  wire logic        ser_wr_eq,
   input  wire logic [15:0] input_eq_level_bits,
   input  wire logic        ser_wr_tx,
   input  wire logic        output_term_on_bit,
   input  wire logic        output_enable_bit,
   input  wire logic        output_current_level_bit,
   input  wire logic [1:0]  output_boost_field,
   // parallel pins
   input  wire logic [2:0]  pin_addr_sel,
   input  wire logic [1:0]  pin_channel_select,
   input  wire logic        pin_eq_level,
   input  wire logic        pin_output_term_on,
   input  wire logic        pin_output_enable,
   input  wire logic        pin_output_current_level,
   input  wire logic [1:0]  pin_output_boost_bus,
   // outputs
   output logic             addr_match,
   output logic             serial_active,
   output logic [1:0]       fast_mode,
   output logic [3:0]       fast_chan,
   output logic [1:0]       aux_mode,
   output logic [3:0]       aux_chan,
   output logic [15:0]      input_term_en,
   output logic [15:0]      eq_high,
   output logic             output_term_en,
   output logic             output_tristate,
   output logic             output_current_high,
   output logic [1:0]       output_boost
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [7:0]          pin_s1;
      logic [7:0]          pin_s2;
      logic [2:0]          adr_s1;
      logic [2:0]          adr_s2;
      swcfg_pkg::swcfg_src_t src;
      logic                rst_seen;
      logic [1:0]          mode;
      logic [3:0]          chan;
      logic [1:0]          amode;
      logic [3:0]          achan;
      logic [15:0]         pulse_sel;
      logic                term_off;
      logic [15:0]         eq;
      logic                oe;
      logic                oterm;
      logic                ocl;
      logic [1:0]          boost;
      logic [3:0]          last_chan;
      logic [21:0]         pcnt;
      // output flops
      logic                o_match;
      logic                o_ser;
      logic [1:0]          o_fmode;
      logic [3:0]          o_fchan;
      logic [1:0]          o_amode;
      logic [3:0]          o_achan;
      logic [15:0]         o_tin;
      logic [15:0]         o_eq;
      logic                o_tout;
      logic                o_tri;
      logic                o_ocl;
      logic [1:0]          o_boost;
   } swcfg_state_t;

   swcfg_state_t st;
   swcfg_state_t next_st;

   logic [7:0] pin_vec;
   assign pin_vec = {pin_output_boost_bus, pin_output_current_level, pin_output_term_on,
                     pin_output_enable, pin_eq_level, pin_channel_select};

   logic [15:0] pulse_mask;

   // one bit per input: termination dropped while pulse runs on selected inputs
   for (genvar i = 0; i < 16; i++) begin : g_pulse
      assign pulse_mask[i] = st.pulse_sel[i] && (st.pcnt != 22'h00_0000);
   end

   // ==========================================================
   // next state
   always_comb begin
      logic ser;
      logic [1:0] pin_ch;
      logic [3:0] new_chan;
      next_st = st;
      ser = (st.src == swcfg_pkg::SWCFG_SRC_SERIAL);
      pin_ch = st.pin_s2[1:0];
      new_chan = ser ? st.chan : {2'h0, pin_ch};
      next_st.pin_s1 = pin_vec;
      next_st.pin_s2 = st.pin_s1;
      next_st.adr_s1 = pin_addr_sel;
      next_st.adr_s2 = st.adr_s1;
      next_st.rst_seen = 1'b1;
      // straps caught on the first edge after reset release
      if (!st.rst_seen) begin
         next_st.oterm = st.pin_s2[4];
         next_st.ocl   = st.pin_s2[5];
      end
      // first serial event latches serial control until reset
      if (ser_access) begin
         next_st.src = swcfg_pkg::SWCFG_SRC_SERIAL;
      end
      if (ser_wr_mode) begin
         next_st.mode  = fast_switch_mode_bits;
         next_st.chan  = ser_fast_chan;
         next_st.amode = ser_aux_mode;
         next_st.achan = ser_aux_chan;
         next_st.oe    = output_enable_bit;
      end
      if (ser_wr_term) begin
         next_st.pulse_sel = input_term_pulse_bits;
         next_st.term_off  = input_term_off;
      end
      if (ser_wr_eq) begin
         next_st.eq = input_eq_level_bits;
      end
      if (ser_wr_tx) begin
         next_st.oterm = output_term_on_bit;
         next_st.ocl   = output_current_level_bit;
         next_st.boost = output_boost_field;
      end
      // a change of routed source restarts the termination pulse
      next_st.last_chan = new_chan;
      if (new_chan != st.last_chan) begin
         next_st.pcnt = PULSE_CYC[21:0];
      end else if (st.pcnt != 22'h00_0000) begin
         next_st.pcnt = st.pcnt - 22'h00_0001;
      end
      // output selectors
      next_st.o_match = (ser_dev_addr == {swcfg_pkg::SWCFG_ADDR_HIGH, st.adr_s2});
      next_st.o_ser   = ser;
      if (ser) begin
         next_st.o_fmode = st.mode;
         next_st.o_fchan = st.chan;
         next_st.o_amode = st.amode;
         next_st.o_achan = st.achan;
         next_st.o_tin   = st.term_off ? 16'h0000 : ~pulse_mask;
         next_st.o_eq    = st.eq;
         next_st.o_tout  = st.oterm;
         next_st.o_tri   = !st.oe;
         next_st.o_ocl   = st.ocl;
         next_st.o_boost = st.boost;
      end else begin
         next_st.o_fmode = swcfg_pkg::SWCFG_MODE_QUAD;
         next_st.o_fchan = {2'h0, pin_ch};
         next_st.o_amode = swcfg_pkg::SWCFG_MODE_QUAD;
         next_st.o_achan = {2'h0, pin_ch};
         next_st.o_tin   = 16'hffff;
         next_st.o_eq    = {16{st.pin_s2[2]}};
         next_st.o_tout  = st.pin_s2[4];
         next_st.o_tri   = !st.pin_s2[3];
         next_st.o_ocl   = st.pin_s2[5];
         next_st.o_boost = st.pin_s2[7:6];
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         st           <= '0;
         st.src       <= swcfg_pkg::SWCFG_SRC_PIN;
         st.mode      <= swcfg_pkg::SWCFG_RST_MODE;
         st.chan      <= swcfg_pkg::SWCFG_RST_CHAN;
         st.amode     <= swcfg_pkg::SWCFG_RST_MODE;
         st.achan     <= swcfg_pkg::SWCFG_RST_CHAN;
         st.pulse_sel <= swcfg_pkg::SWCFG_RST_PULSE;
         st.term_off  <= swcfg_pkg::SWCFG_RST_TERMOFF;
         st.eq        <= swcfg_pkg::SWCFG_RST_EQ;
         st.oe        <= swcfg_pkg::SWCFG_RST_OE;
         st.boost     <= swcfg_pkg::SWCFG_RST_BOOST;
         st.o_tin     <= 16'hffff;
         st.o_tri     <= 1'b1;
         // synchronisers keep running so the straps are settled at release
         st.pin_s1    <= pin_vec;
         st.pin_s2    <= st.pin_s1;
         st.adr_s1    <= pin_addr_sel;
         st.adr_s2    <= st.adr_s1;
      end else begin
         st <= next_st;
      end
   end

   assign addr_match          = st.o_match;
   assign serial_active       = st.o_ser;
   assign fast_mode           = st.o_fmode;
   assign fast_chan           = st.o_fchan;
   assign aux_mode            = st.o_amode;
   assign aux_chan            = st.o_achan;
   assign input_term_en       = st.o_tin;
   assign eq_high             = st.o_eq;
   assign output_term_en      = st.o_tout;
   assign output_tristate     = st.o_tri;
   assign output_current_high = st.o_ocl;
   assign output_boost        = st.o_boost;

endmodule // swcfg_ctrl

/* tb/swcfg_ctrl_monitor.sv */
// assertions on the switch configuration control ports
// bound into swcfg_ctrl; one mclk domain, synchronous active-high rst
module swcfg_ctrl_monitor #(
   parameter int PULSE_CYC = 20
) (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        ser_access,
   input wire logic        ser_wr_mode,
   input wire logic        ser_wr_term,
   input wire logic        ser_wr_eq,
   input wire logic [1:0]  fast_switch_mode_bits,
   input wire logic        input_term_off,
   input wire logic [15:0] input_eq_level_bits,
   input wire logic        output_enable_bit,
   input wire logic        serial_active,
   input wire logic [1:0]  fast_mode,
   input wire logic [3:0]  fast_chan,
   input wire logic [1:0]  aux_mode,
   input wire logic [3:0]  aux_chan,
   input wire logic [15:0] input_term_en,
   input wire logic [15:0] eq_high,
   input wire logic        output_tristate
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_serial_sticky: assert property (serial_active |=> serial_active)
      else $error("serial control dropped without reset");
   a_access_latch: assert property (ser_access |-> ##2 serial_active)
      else $error("control event did not take over");
   a_reset_default: assert property ($fell(rst) |-> !serial_active
      && output_tristate && input_term_en == 16'hffff && eq_high == 16'h0000)
      else $error("defaults missing after reset");
   a_pin_term_on: assert property (!serial_active |-> input_term_en == 16'hffff)
      else $error("termination changed under pin control");
   a_pin_quad_lock: assert property (!serial_active |-> fast_mode == 2'h0
      && aux_mode == 2'h0 && fast_chan == aux_chan)
      else $error("pin control not quad or not locked");
   a_pin_eq_global: assert property (!serial_active
      |-> eq_high == 16'h0000 || eq_high == 16'hffff)
      else $error("pin equalizer not global");
   a_eq_write: assert property (ser_wr_eq && serial_active
      |-> ##2 eq_high == $past(input_eq_level_bits, 2))
      else $error("equalizer bits not applied");
   a_mode_write: assert property (ser_wr_mode && serial_active |-> ##2
      fast_mode == $past(fast_switch_mode_bits, 2) && output_tristate == !$past(output_enable_bit, 2))
      else $error("mode write not applied");
   a_term_off: assert property (ser_wr_term && input_term_off && serial_active
      |-> ##2 input_term_en == 16'h0000)
      else $error("termination off not applied");
   c_single: cover property (serial_active && fast_mode == 2'h2);
   c_takeover: cover property ($rose(serial_active));
   c_all_off: cover property (serial_active && input_term_en == 16'h0000);
endmodule // swcfg_ctrl_monitor

bind swcfg_ctrl swcfg_ctrl_monitor #(.PULSE_CYC(PULSE_CYC)) u_monitor (
   .mclk, .rst, .ser_access, .ser_wr_mode, .ser_wr_term, .ser_wr_eq, .fast_switch_mode_bits,
   .input_term_off, .input_eq_level_bits, .output_enable_bit, .serial_active, .fast_mode,
   .fast_chan, .aux_mode, .aux_chan, .input_term_en, .eq_high, .output_tristate);

/* tb/swcfg_ctrl_tb_top.sv */
// self-checking bench for swcfg_ctrl, pulse shortened to 20 cycles
// assumes 25 MHz mclk; inputs change on the falling edge only
module swcfg_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst = 1'b1, go = 1'b0, acc = 1'b0, toff = 1'b0, oeb = 1'b0, tob = 1'b0;
   logic ocb = 1'b0, peq = 1'b0, pto = 1'b1, poe = 1'b0, pocl = 1'b1, sa;
   logic [1:0] kind = 2'h0, fm = 2'h0, am = 2'h0, bst = 2'h0, pch = 2'h0, pbst = 2'h0;
   logic [2:0] padr = 3'h0;
   logic [3:0] fc = 4'h0, ac = 4'h0, wr, fast_chan, aux_chan;
   logic [6:0] dev = 7'h00;
   logic [15:0] pul = 16'h0000, eqb = 16'h0000, input_term_en, eq_high;
   logic addr_match, serial_active, output_term_en, output_tristate, output_current_high;
   logic [1:0] fast_mode, aux_mode, output_boost;
   int failures = 0, checks = 0;
   initial forever #20 mclk = ~mclk;
   swcfg_master_model PRT (.go(go), .acc(acc), .kind(kind), .ser_access(sa), .ser_wr(wr));
   swcfg_ctrl #(.PULSE_CYC(20)) DUT (.mclk, .rst, .ser_dev_addr(dev), .ser_access(sa),
      .ser_wr_mode(wr[0]), .fast_switch_mode_bits(fm), .ser_fast_chan(fc), .ser_aux_mode(am),
      .ser_aux_chan(ac), .ser_wr_term(wr[1]), .input_term_pulse_bits(pul), .input_term_off(toff),
      .ser_wr_eq(wr[2]), .input_eq_level_bits(eqb), .ser_wr_tx(wr[3]), .output_term_on_bit(tob),
      .output_enable_bit(oeb), .output_current_level_bit(ocb), .output_boost_field(bst),
      .pin_addr_sel(padr), .pin_channel_select(pch), .pin_eq_level(peq), .pin_output_term_on(pto),
      .pin_output_enable(poe), .pin_output_current_level(pocl), .pin_output_boost_bus(pbst),
      .addr_match, .serial_active, .fast_mode, .fast_chan, .aux_mode, .aux_chan,
      .input_term_en, .eq_high, .output_term_en, .output_tristate, .output_current_high,
      .output_boost);
   // ==========================================================
   // shared tasks
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (s !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic ser(input logic a, input logic [1:0] k);
      acc = a;
      kind = k;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(4);
   endtask
   task automatic report_and_stop;
      if (failures == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_pins;
      for (int i = 0; i < 4; i++) begin
         pch = i[1:0];
         pbst = i[1:0];
         peq = i[0];
         pto = i[0];
         poe = i[0]; // outputs only enabled while terminated
         pocl = i[1];
         tick(6);
         chk("fmode", 2'h0, fast_mode);
         chk("amode", 2'h0, aux_mode);
         chk("fchan", {2'h0, pch}, fast_chan);
         chk("achan", {2'h0, pch}, aux_chan);
         chk("eq", {16{peq}}, eq_high);
         chk("tri", !poe, output_tristate);
         chk("boost", pbst, output_boost);
         chk("oterm", pto, output_term_en);
         chk("ocur", pocl, output_current_high);
      end
      toff = 1'b1;
      ser(1'b0, 2'h1);
      chk("refused", 16'hffff, input_term_en);
      chk("src", 1'h0, serial_active);
      toff = 1'b0;
   endtask
   task automatic t_addr;
      for (int a = 0; a < 8; a++) begin
         padr = a[2:0];
         dev = {swcfg_pkg::SWCFG_ADDR_HIGH, a[2:0]};
         tick(5);
         chk("match", 1'h1, addr_match);
         dev[0] = ~dev[0];
         tick(2);
         chk("miss", 1'h0, addr_match);
      end
   endtask
   task automatic t_serial;
      for (int m = 0; m < 3; m++) begin
         fm = m[1:0];
         am = 2'h2 - m[1:0];
         fc = 4'h5 + m[3:0];
         ac = 4'h3;
         oeb = m[0];
         ser(1'b1, 2'h0);
         chk("src", 1'h1, serial_active);
         chk("fmode", fm, fast_mode);
         chk("amode", am, aux_mode);
         chk("fchan", fc, fast_chan);
         chk("achan", ac, aux_chan);
         chk("tri", !oeb, output_tristate);
      end
      peq = 1'b1;
      pch = 2'h2;
      tick(6);
      chk("eq", 16'h0000, eq_high);
      chk("fchan", fc, fast_chan);
      eqb = 16'ha5a5;
      ser(1'b1, 2'h2);
      chk("eq", eqb, eq_high);
      for (int v = 0; v < 2; v++) begin
         tob = v[0];
         ocb = v[0];
         bst = 2'h2 + v[1:0];
         ser(1'b1, 2'h3);
         chk("oterm", tob, output_term_en);
         chk("ocur", ocb, output_current_high);
         chk("boost", bst, output_boost);
      end
      toff = 1'b1;
      ser(1'b1, 2'h1);
      chk("off", 16'h0000, input_term_en);
      toff = 1'b0;
      pul = 16'h8001;
      ser(1'b1, 2'h1);
      chk("on", 16'hffff, input_term_en);
      fc = fc + 4'h1;
      ser(1'b1, 2'h0);
      chk("pulse", 16'h7ffe, input_term_en);
      tick(25);
      chk("pulse", 16'hffff, input_term_en);
   endtask
   task automatic t_reset(input logic strap);
      pocl = strap;
      pto = strap;
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
      tick(6);
      chk("src", 1'h0, serial_active);
      chk("term", 16'hffff, input_term_en);
      chk("oterm", strap, output_term_en);
      chk("ocur", strap, output_current_high);
      chk("eq", {16{peq}}, eq_high);
   endtask
   initial begin
      t_reset(1'b1);
      t_pins();
      t_addr();
      t_serial();
      t_reset(1'b0);
      report_and_stop();
   end
   initial begin
      repeat (3000) @(posedge mclk);
      failures++;
      report_and_stop();
   end
endmodule // swcfg_ctrl_tb_top

/* tb/swcfg_master_model.sv */
// serial controller stand-in: one go cycle becomes decoded write strobes
// assumes the bench holds go for exactly one cycle, changed off the rising edge
module swcfg_master_model (
   input  wire logic       go,
   input  wire logic       acc,
   input  wire logic [1:0] kind,
   output logic            ser_access,
   output logic [3:0]      ser_wr
);
   timeunit 1ns;
   timeprecision 1ps;
   // acc low sends a bare write with no control event, to see it refused
   assign ser_access = go & acc;
   assign ser_wr     = go ? 4'h1 << kind : 4'h0;
endmodule // swcfg_master_model
